// ---- design/asl_pkg.sv ----
package asl_pkg;

  // ----------------------------------------
  // register map, byte addresses on the bus
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PSW = 8'h04;
  localparam logic [7:0] OFS_OPND = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_MEM = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_TIME = 8'h18;
  localparam logic [2:0] OFS_GPR_PAGE = 3'h1;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_FORM_LSB = 4;
  localparam int CTRL_RSEL_LSB = 8;
  localparam int CTRL_EXT = 11;
  localparam int CTRL_BUSY = 16;
  localparam int CTRL_ERR = 17;
  localparam int PSW_CY = 0;
  localparam int PSW_AC = 4;
  localparam int PSW_Z = 6;
  localparam int STAT_MEMWR = 24;

  // ----------------------------------------
  // register file slots and address base
  // ----------------------------------------
  localparam logic [2:0] GPR_A = 3'h1;
  localparam logic [2:0] GPR_C = 3'h2;
  localparam logic [2:0] GPR_B = 3'h3;
  localparam logic [2:0] GPR_L = 3'h6;
  localparam logic [2:0] GPR_H = 3'h7;
  localparam logic [15:0] SHORT_BASE = 16'hFE00;

  // ----------------------------------------
  // lengths in bytes and clock counts
  // ----------------------------------------
  localparam logic [1:0] LEN_PTR = 2'h1;
  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;
  localparam logic [4:0] CLK_SHORT = 5'h04;
  localparam logic [4:0] CLK_SIMM_INT = 5'h06;
  localparam logic [4:0] CLK_SIMM_EXT = 5'h08;
  localparam logic [4:0] CLK_SAD_EXT = 5'h05;
  localparam logic [4:0] CLK_LONG = 5'h08;
  localparam logic [4:0] CLK_LONG_EXT = 5'h09;
  localparam logic [4:0] CLK_PTR_EXT = 5'h05;
  localparam logic [4:0] CNT_TAIL = 5'h02;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ASL_SUBTRACT_OP = 3'h0,
    ASL_SUBTRACT_BORROW_OP = 3'h1,
    ASL_AND_OP = 3'h2,
    ASL_OR_OP = 3'h3,
    ASL_XOR_OP = 3'h4,
    ASL_COMPARE_OP = 3'h5
  } asl_op_e;

  typedef enum logic [3:0] {
    F_IMM = 4'h0,
    F_SHORT_IMM = 4'h1,
    F_A_REG = 4'h2,
    F_REG_A = 4'h3,
    F_A_SHORT = 4'h4,
    F_A_ABS = 4'h5,
    F_A_PTR = 4'h6,
    F_A_PTR_DISP = 4'h7,
    F_A_PTR_B = 4'h8,
    F_A_PTR_C = 4'h9
  } asl_form_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_EXEC = 2'h1,
    S_COMMIT = 2'h3
  } asl_fsm_e;

  typedef struct packed {
    logic [1:0] len;
    logic [4:0] clocks;
  } asl_time_s;

  typedef struct packed {
    asl_fsm_e fsm;
    logic busy;
    logic [4:0] cnt;
    asl_op_e op;
    asl_form_e form;
    logic [2:0] rsel;
    logic ext;
    logic err;
    logic [7:0] imm;
    logic [7:0] disp;
    logic [15:0] abs_loc;
    logic [7:0] short_loc;
    logic [7:0] mem_data;
    logic [3:0] waits;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
    logic [7:0][7:0] gpr;
    logic [15:0] ea;
    logic [7:0] mem_result;
    logic mem_wr;
    asl_time_s tm;
    logic waitreq;
    logic [31:0] rdata;
  } asl_state_s;

endpackage

// ---- design/asl_alu_sub_logic.sv ----
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module asl_alu_sub_logic (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // status
  output logic BUSY_OUT
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  asl_pkg::asl_state_s st;
  asl_pkg::asl_state_s nx;

  logic [31:0] rd_word;
  logic [31:0] wv;
  logic wr_take;
  logic start_req;
  logic err_clr;
  logic start_ok;
  asl_pkg::asl_op_e n_op;
  asl_pkg::asl_form_e n_form;
  logic [2:0] n_rsel;
  logic n_ext;
  logic [7:0] a_val;
  logic [7:0] b_val;
  logic cin;
  logic [8:0] diff;
  logic [4:0] hdiff;
  logic [7:0] res;
  logic arith;
  logic [15:0] ptr;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // counts are the internal-ROM program figures; no extra fetch cost is modelled
  function automatic asl_pkg::asl_time_s timing(input asl_pkg::asl_form_e f,
                                                 input logic ext, input logic [3:0] n);
    asl_pkg::asl_time_s t;
    t.len = asl_pkg::LEN_SHORT;
    t.clocks = asl_pkg::CLK_SHORT;
    case (f)
      asl_pkg::F_IMM, asl_pkg::F_A_REG, asl_pkg::F_REG_A: begin
        // no data access: always the first count
        t.len = asl_pkg::LEN_SHORT;
        t.clocks = asl_pkg::CLK_SHORT;
      end
      asl_pkg::F_SHORT_IMM: begin
        // result write stays inside the chip here, so no write wait term
        t.len = asl_pkg::LEN_LONG;
        t.clocks = ext ? asl_pkg::CLK_SIMM_EXT : asl_pkg::CLK_SIMM_INT;
      end
      asl_pkg::F_A_SHORT: begin
        t.len = asl_pkg::LEN_SHORT;
        t.clocks = ext ? asl_pkg::CLK_SAD_EXT : asl_pkg::CLK_SHORT;
      end
      asl_pkg::F_A_ABS: begin
        t.len = asl_pkg::LEN_LONG;
        t.clocks = ext ? asl_pkg::CLK_LONG_EXT + {1'b0, n} : asl_pkg::CLK_LONG;
      end
      asl_pkg::F_A_PTR: begin
        t.len = asl_pkg::LEN_PTR;
        t.clocks = ext ? asl_pkg::CLK_PTR_EXT + {1'b0, n} : asl_pkg::CLK_SHORT;
      end
      asl_pkg::F_A_PTR_DISP, asl_pkg::F_A_PTR_B, asl_pkg::F_A_PTR_C: begin
        // indexed forms pay the long count although they are only two bytes
        t.len = asl_pkg::LEN_SHORT;
        t.clocks = ext ? asl_pkg::CLK_LONG_EXT + {1'b0, n} : asl_pkg::CLK_LONG;
      end
      default: begin
        // refused forms never start, so these figures are never shown
        t.len = asl_pkg::LEN_SHORT;
        t.clocks = asl_pkg::CLK_SHORT;
      end
    endcase
    return t;
  endfunction

  // ----------------------------------------
  // register readback
  // ----------------------------------------
  always_comb begin
    rd_word = asl_pkg::RST_WORD;
    if (AVS_ADDRESS_IN[7:5] == asl_pkg::OFS_GPR_PAGE && AVS_ADDRESS_IN[1:0] == 2'h0) begin
      rd_word[7:0] = st.gpr[AVS_ADDRESS_IN[4:2]];
    end else begin
      case (AVS_ADDRESS_IN)
        asl_pkg::OFS_CTRL: begin
          rd_word[asl_pkg::CTRL_OP_LSB +: 3] = st.op;
          rd_word[asl_pkg::CTRL_FORM_LSB +: 4] = st.form;
          rd_word[asl_pkg::CTRL_RSEL_LSB +: 3] = st.rsel;
          rd_word[asl_pkg::CTRL_EXT] = st.ext;
          rd_word[asl_pkg::CTRL_BUSY] = st.busy;
          rd_word[asl_pkg::CTRL_ERR] = st.err;
        end
        asl_pkg::OFS_PSW: begin
          rd_word[asl_pkg::PSW_Z] = st.zero_flag;
          rd_word[asl_pkg::PSW_AC] = st.aux_carry_flag;
          rd_word[asl_pkg::PSW_CY] = st.carry_flag;
        end
        asl_pkg::OFS_OPND: begin
          rd_word[15:0] = {st.disp, st.imm};
        end
        asl_pkg::OFS_ADDR: begin
          rd_word[23:0] = {st.short_loc, st.abs_loc};
        end
        asl_pkg::OFS_MEM: begin
          rd_word[11:0] = {st.waits, st.mem_data};
        end
        asl_pkg::OFS_STAT: begin
          rd_word[23:0] = {st.mem_result, st.ea};
          rd_word[asl_pkg::STAT_MEMWR] = st.mem_wr;
        end
        asl_pkg::OFS_TIME: begin
          // clock count in bits 12:8, length in bits 1:0
          rd_word[12:0] = {st.tm.clocks, 6'h00, st.tm.len};
        end
        default: begin
          rd_word = asl_pkg::RST_WORD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  always_comb begin
    ptr = {st.gpr[asl_pkg::GPR_H], st.gpr[asl_pkg::GPR_L]};
    a_val = st.gpr[asl_pkg::GPR_A];
    b_val = st.mem_data;
    case (st.form)
      asl_pkg::F_IMM: begin
        b_val = st.imm;
      end
      asl_pkg::F_SHORT_IMM: begin
        a_val = st.mem_data;
        b_val = st.imm;
      end
      asl_pkg::F_A_REG: begin
        b_val = st.gpr[st.rsel];
      end
      asl_pkg::F_REG_A: begin
        a_val = st.gpr[st.rsel];
        b_val = st.gpr[asl_pkg::GPR_A];
      end
      default: begin
        // memory forms: software hands the operand byte in beforehand
        b_val = st.mem_data;
      end
    endcase
    cin = (st.op == asl_pkg::ASL_SUBTRACT_BORROW_OP) ? st.carry_flag : 1'b0;
    // nine bits wide so bit 8 is the borrow out of bit 7
    diff = {1'b0, a_val} - {1'b0, b_val} - {8'h00, cin};
    // the low nibble alone gives the borrow out of bit 3
    hdiff = {1'b0, a_val[3:0]} - {1'b0, b_val[3:0]} - {4'h0, cin};
    arith = 1'b0;
    case (st.op)
      asl_pkg::ASL_AND_OP: begin
        res = a_val & b_val;
      end
      asl_pkg::ASL_OR_OP: begin
        res = a_val | b_val;
      end
      asl_pkg::ASL_XOR_OP: begin
        res = a_val ^ b_val;
      end
      default: begin
        res = diff[7:0];
        arith = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    wv = merge(rd_word, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    // answer one cycle after the request appears, then drop for one cycle
    if ((AVS_READ_IN || AVS_WRITE_IN) && st.waitreq) begin
      nx.waitreq = 1'b0;
      nx.rdata = rd_word;
    end else begin
      nx.waitreq = 1'b1;
    end
    wr_take = AVS_WRITE_IN && !st.waitreq;
    start_req = wr_take && AVS_ADDRESS_IN == asl_pkg::OFS_CTRL &&
                AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[asl_pkg::CTRL_START];
    err_clr = wr_take && AVS_ADDRESS_IN == asl_pkg::OFS_CTRL &&
              AVS_BYTEENABLE_IN[2] && AVS_WRITEDATA_IN[asl_pkg::CTRL_ERR];
    n_op = asl_pkg::asl_op_e'(wv[asl_pkg::CTRL_OP_LSB +: 3]);
    n_form = asl_pkg::asl_form_e'(wv[asl_pkg::CTRL_FORM_LSB +: 4]);
    n_rsel = wv[asl_pkg::CTRL_RSEL_LSB +: 3];
    n_ext = wv[asl_pkg::CTRL_EXT];
    // refused: spare op codes, spare forms, and the accumulator paired with itself in the A,reg form
    start_ok = n_op <= asl_pkg::ASL_COMPARE_OP && n_form <= asl_pkg::F_A_PTR_C &&
               !(n_form == asl_pkg::F_A_REG && n_rsel == asl_pkg::GPR_A);
    if (err_clr) begin
      nx.err = 1'b0;
    end
    // register writes only land while idle; during a run they are dropped, except the error clear
    if (wr_take && st.fsm == asl_pkg::S_IDLE) begin
      if (AVS_ADDRESS_IN[7:5] == asl_pkg::OFS_GPR_PAGE && AVS_ADDRESS_IN[1:0] == 2'h0) begin
        nx.gpr[AVS_ADDRESS_IN[4:2]] = wv[7:0];
      end
      case (AVS_ADDRESS_IN)
        asl_pkg::OFS_CTRL: begin
          nx.op = n_op;
          nx.form = n_form;
          nx.rsel = n_rsel;
          nx.ext = n_ext;
        end
        asl_pkg::OFS_PSW: begin
          nx.zero_flag = wv[asl_pkg::PSW_Z];
          nx.aux_carry_flag = wv[asl_pkg::PSW_AC];
          nx.carry_flag = wv[asl_pkg::PSW_CY];
        end
        asl_pkg::OFS_OPND: begin
          {nx.disp, nx.imm} = wv[15:0];
        end
        asl_pkg::OFS_ADDR: begin
          {nx.short_loc, nx.abs_loc} = wv[23:0];
        end
        asl_pkg::OFS_MEM: begin
          {nx.waits, nx.mem_data} = wv[11:0];
        end
        default: nx.op = st.op;
      endcase
    end
    case (st.fsm)
      asl_pkg::S_IDLE: begin
        if (start_req && !start_ok) begin
          // set beats a clear carried in the same write
          nx.err = 1'b1;
        end else if (start_req) begin
          nx.fsm = asl_pkg::S_EXEC;
          nx.busy = 1'b1;
          // the previous run's memory result is withdrawn at the new start
          nx.mem_wr = 1'b0;
          nx.tm = timing(n_form, n_ext, st.waits);
          // busy spans exactly tm.clocks cycles, one per cpu clock
          nx.cnt = nx.tm.clocks - asl_pkg::CNT_TAIL;
          case (n_form)
            asl_pkg::F_A_ABS: begin
              nx.ea = st.abs_loc;
            end
            asl_pkg::F_SHORT_IMM, asl_pkg::F_A_SHORT: begin
              nx.ea = asl_pkg::SHORT_BASE | {8'h00, st.short_loc};
            end
            asl_pkg::F_A_PTR: begin
              nx.ea = ptr;
            end
            asl_pkg::F_A_PTR_DISP: begin
              nx.ea = ptr + {8'h00, st.disp};
            end
            asl_pkg::F_A_PTR_B: begin
              nx.ea = ptr + {8'h00, st.gpr[asl_pkg::GPR_B]};
            end
            asl_pkg::F_A_PTR_C: begin
              nx.ea = ptr + {8'h00, st.gpr[asl_pkg::GPR_C]};
            end
            default: begin
              nx.ea = st.ea;
            end
          endcase
        end
      end
      asl_pkg::S_EXEC: begin
        // loaded two short: the cycle at zero count and the commit cycle make up the rest
        if (st.cnt == 5'h00) begin
          nx.fsm = asl_pkg::S_COMMIT;
        end else begin
          nx.cnt = st.cnt - 5'h01;
        end
      end
      asl_pkg::S_COMMIT: begin
        nx.fsm = asl_pkg::S_IDLE;
        nx.busy = 1'b0;
        nx.zero_flag = (res == 8'h00);
        if (arith) begin
          // logic ops leave both carries alone
          nx.carry_flag = diff[8];
          nx.aux_carry_flag = hdiff[4];
        end
        // compare leaves only its flags behind
        if (st.op != asl_pkg::ASL_COMPARE_OP) begin
          case (st.form)
            asl_pkg::F_SHORT_IMM: begin
              nx.mem_result = res;
              nx.mem_wr = 1'b1;
            end
            asl_pkg::F_REG_A: begin
              nx.gpr[st.rsel] = res;
            end
            default: begin
              nx.gpr[asl_pkg::GPR_A] = res;
            end
          endcase
        end
      end
      default: begin
        nx.fsm = asl_pkg::S_IDLE;
        nx.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st <= '0;
      st.fsm <= asl_pkg::S_IDLE;
      st.op <= asl_pkg::ASL_SUBTRACT_OP;
      st.form <= asl_pkg::F_IMM;
      st.gpr <= {8{asl_pkg::RST_BYTE}};
      st.waitreq <= 1'b1;
      st.rdata <= asl_pkg::RST_WORD;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign AVS_READDATA_OUT = st.rdata;
  assign AVS_WAITREQUEST_OUT = st.waitreq;
  assign BUSY_OUT = st.busy;

endmodule

`default_nettype wire

// ---- tb/asl_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module asl_mem_model (
  // access
  input wire logic [15:0] addr_in,
  input wire logic ext_in,
  // answer
  output logic [7:0] data_out,
  output logic [3:0] waits_out
);
  // contents differ by address so a wrong effective address shows up in the result
  assign data_out = addr_in[7:0] ^ addr_in[15:8] ^ 8'h5a;
  // fast internal ram never stalls; outside it the wait count varies by address
  assign waits_out = ext_in ? {1'h0, addr_in[2:0]} : 4'h0;
endmodule

`default_nettype wire

// ---- tb/asl_alu_sub_logic_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module asl_chk (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // bus and status
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic BUSY_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----------------------------------------
  // expected run length, tracked from full-word writes
  // ----------------------------------------
  logic [31:0] d;
  logic [3:0] f;
  logic req, ack, go, ok, rdack;
  logic [3:0] n;
  logic [4:0] clk_c, cnt;
  logic [1:0] len_c;
  assign d = AVS_WRITEDATA_IN;
  assign f = d[7:4];
  assign req = AVS_READ_IN || AVS_WRITE_IN;
  // writes while busy are dropped, so only idle writes count
  assign ack = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && !BUSY_OUT && AVS_BYTEENABLE_IN == 4'hf;
  assign rdack = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  assign go = ack && AVS_ADDRESS_IN == asl_pkg::OFS_CTRL && d[0];
  assign ok = d[3:1] < 3'h6 && f < 4'ha && !(f == 4'h2 && d[10:8] == asl_pkg::GPR_A);

  function automatic logic [4:0] exp_clk(input logic [3:0] fm, input logic x, input logic [3:0] w);
    case (fm)
      4'h1: return x ? 5'h08 : 5'h06;
      4'h4: return x ? 5'h05 : 5'h04;
      4'h6: return x ? 5'h05 + {1'h0, w} : 5'h04;
      4'h5, 4'h7, 4'h8, 4'h9: return x ? 5'h09 + {1'h0, w} : 5'h08;
      default: return 5'h04;
    endcase
  endfunction

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      n <= 4'h0;
      clk_c <= 5'h00;
      len_c <= 2'h0;
      cnt <= 5'h00;
    end else begin
      cnt <= BUSY_OUT ? cnt + 5'h01 : 5'h00;
      if (ack && AVS_ADDRESS_IN == asl_pkg::OFS_MEM) begin
        n <= d[11:8];
      end
      if (go && ok) begin
        len_c <= f == 4'h6 ? 2'h1 : (f == 4'h1 || f == 4'h5) ? 2'h3 : 2'h2;
        clk_c <= exp_clk(f, d[11], n);
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  wait_ack_a: assert property (req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("request not acknowledged after one cycle");
  wait_pulse_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("acknowledge longer than one cycle");
  wait_idle_a: assert property (!req |=> AVS_WAITREQUEST_OUT)
    else $error("acknowledge without request");
  start_busy_a: assert property (go && ok |=> BUSY_OUT)
    else $error("valid start did not raise busy");
  bad_start_a: assert property (go && !ok |=> !BUSY_OUT [*2])
    else $error("invalid start ran");
  busy_len_a: assert property ($fell(BUSY_OUT) |-> cnt == clk_c)
    else $error("run length wrong");
  time_field_a: assert property (rdack && AVS_ADDRESS_IN == asl_pkg::OFS_TIME && !BUSY_OUT
    |-> AVS_READDATA_OUT[12:8] == clk_c && AVS_READDATA_OUT[1:0] == len_c)
    else $error("timing register wrong");
  unmapped_zero_a: assert property (rdack && (AVS_ADDRESS_IN[1:0] != 2'h0
    || AVS_ADDRESS_IN == 8'h1c || AVS_ADDRESS_IN > 8'h3c) |-> AVS_READDATA_OUT == 32'h0000_0000)
    else $error("unmapped read not zero");
  psw_bits_a: assert property (rdack && AVS_ADDRESS_IN == asl_pkg::OFS_PSW
    |-> (AVS_READDATA_OUT & 32'hffff_ffae) == 32'h0000_0000)
    else $error("flag register spare bits set");
  cover property (go && ok && d[11]);
  cover property (go && !ok);
  cover property ($fell(BUSY_OUT) && cnt > 5'h08);
endmodule

bind asl_alu_sub_logic asl_chk u_chk (.SYS_CLK_IN, .RST_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN,
  .AVS_WRITE_IN, .AVS_WRITEDATA_IN, .AVS_BYTEENABLE_IN, .AVS_READDATA_OUT,
  .AVS_WAITREQUEST_OUT, .BUSY_OUT);

`default_nettype wire

// ---- tb/test_asl_alu_sub_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module test_asl_alu_sub_logic;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq;
  logic busy;
  logic [15:0] m_addr = 16'h1234;
  logic m_ext = 1'h0;
  logic [7:0] m_data;
  logic [3:0] m_wait;
  logic [31:0] r;
  int errors = 0;
  int compares = 0;

  asl_alu_sub_logic uut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .BUSY_OUT(busy));
  asl_mem_model mem (.addr_in(m_addr), .ext_in(m_ext), .data_out(m_data), .waits_out(m_wait));

  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // bus and run helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // hold the request until the rising edge that samples waitrequest low
    @(posedge clk);
    while (wreq !== 1'h0) begin
      @(posedge clk);
    end
    r = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask

  task automatic settle(output int k);
    k = 0;
    @(negedge clk);
    while (busy === 1'h1) begin
      k++;
      @(negedge clk);
    end
  endtask

  task automatic run(input logic [2:0] op, input logic [3:0] f, input logic x,
                     input logic [2:0] rs, input logic [4:0] c);
    int k;
    bus(1'h1, asl_pkg::OFS_CTRL, {20'h0_0000, x, rs, f, op, 1'h1});
    settle(k);
    `CHK("busy cycles", c, k[4:0])
  endtask

  // returns result byte and expected flag byte
  function automatic logic [15:0] ref_alu(input logic [2:0] op, input logic [7:0] a, b, p);
    logic [8:0] d;
    logic [4:0] h;
    logic c;
    c = (op == 3'h1) ? p[0] : 1'h0;
    d = {1'h0, a} - {1'h0, b} - {8'h00, c};
    h = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, c};
    if (op == 3'h2) d = {1'h0, a & b};
    if (op == 3'h3) d = {1'h0, a | b};
    if (op == 3'h4) d = {1'h0, a ^ b};
    if (op inside {3'h2, 3'h3, 3'h4}) return {d[7:0], 1'h0, d[7:0] == 8'h00, 1'h0, p[4], 3'h0, p[0]};
    return {d[7:0], 1'h0, d[7:0] == 8'h00, 1'h0, h[4], 3'h0, d[8]};
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] al [5] = '{asl_pkg::OFS_PSW, 8'h24, asl_pkg::OFS_CTRL, 8'h1c, 8'h06};
    `CHK("idle wait", 1'h1, wreq)
    foreach (al[i]) begin
      bus(1'h0, al[i], 32'h0000_0000);
      `CHK("reset or unmapped read", 32'h0000_0000, r)
    end
  endtask

  task automatic t_forms();
    // entries are {op, form, external}
    logic [7:0] cases [18] = '{8'h0a, 8'h0b, 8'h02, 8'h03, 8'h2f, 8'h20, 8'h04, 8'h26, 8'h0d,
      8'h4c, 8'h53, 8'h6e, 8'h6d, 8'h8b, 8'ha9, 8'hb0, 8'ha7, 8'h42};
    logic [2:0] op;
    logic [3:0] f;
    logic x;
    logic [7:0] a, b;
    logic [15:0] e, ea;
    logic [4:0] c;
    bus(1'h1, 8'h3c, 32'h0000_0012);
    bus(1'h1, 8'h38, 32'h0000_0034);
    bus(1'h1, 8'h2c, 32'h0000_0005);
    bus(1'h1, asl_pkg::OFS_OPND, 32'h0000_200f);
    bus(1'h1, asl_pkg::OFS_ADDR, 32'h0040_f123);
    foreach (cases[i]) begin
      {op, f, x} = cases[i];
      ea = (f == 4'h1 || f == 4'h4) ? asl_pkg::SHORT_BASE | 16'h0040 : f == 4'h5 ? 16'hf123 :
           f == 4'h7 ? 16'h1254 : f == 4'h8 ? 16'h1239 : f == 4'h9 ? 16'h123b : 16'h1234;
      m_addr = ea;
      m_ext = x;
      @(negedge clk);
      bus(1'h1, asl_pkg::OFS_MEM, {20'h0_0000, m_wait, m_data});
      bus(1'h1, 8'h24, 32'h0000_003c);
      bus(1'h1, 8'h28, 32'h0000_0007);
      bus(1'h1, asl_pkg::OFS_PSW, 32'h0000_0011);
      a = (f == 4'h1) ? m_data : (f == 4'h3) ? 8'h07 : 8'h3c;
      b = (f == 4'h0 || f == 4'h1) ? 8'h0f : f == 4'h2 ? 8'h07 : f == 4'h3 ? 8'h3c : m_data;
      c = 5'h04;
      if (f == 4'h1) c = x ? 5'h08 : 5'h06;
      if (f == 4'h4) c = x ? 5'h05 : 5'h04;
      if (f == 4'h6) c = x ? 5'h05 + {1'h0, m_wait} : 5'h04;
      if (f inside {4'h5, 4'h7, 4'h8, 4'h9}) c = x ? 5'h09 + {1'h0, m_wait} : 5'h08;
      e = ref_alu(op, a, b, 8'h11);
      run(op, f, x, asl_pkg::GPR_C, c);
      bus(1'h0, asl_pkg::OFS_TIME, 32'h0000_0000);
      `CHK("length", f == 4'h6 ? 2'h1 : (f == 4'h1 || f == 4'h5) ? 2'h3 : 2'h2, r[1:0])
      `CHK("clocks", c, r[12:8])
      bus(1'h0, asl_pkg::OFS_PSW, 32'h0000_0000);
      `CHK("flags", e[7:0], r[7:0])
      bus(1'h0, 8'h24, 32'h0000_0000);
      `CHK("acc", (op == 3'h5 || f == 4'h1 || f == 4'h3) ? 8'h3c : e[15:8], r[7:0])
      bus(1'h0, 8'h28, 32'h0000_0000);
      `CHK("reg", (op != 3'h5 && f == 4'h3) ? e[15:8] : 8'h07, r[7:0])
      if (!(f inside {4'h0, 4'h2, 4'h3})) begin
        bus(1'h0, asl_pkg::OFS_STAT, 32'h0000_0000);
        `CHK("address", ea, r[15:0])
        if (f == 4'h1 && op != 3'h5) `CHK("memory result", ({1'h1, e[15:8]}), r[24:16])
      end
    end
  endtask

  task automatic t_refuse();
    for (int i = 0; i < 3; i++) begin
      run(i == 0 ? 3'h6 : 3'h0, i == 1 ? 4'ha : i == 2 ? 4'h2 : 4'h0, 1'h0,
          i == 2 ? asl_pkg::GPR_A : asl_pkg::GPR_C, 5'h00);
      bus(1'h0, asl_pkg::OFS_CTRL, 32'h0000_0000);
      `CHK("error set", 1'h1, r[17])
      bus(1'h1, asl_pkg::OFS_CTRL, 32'h0002_0000);
    end
    // a refused start and an error clear in one write: the set wins
    bus(1'h1, asl_pkg::OFS_CTRL, 32'h0002_000d);
    bus(1'h0, asl_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK("error set wins", 1'h1, r[17])
    bus(1'h1, asl_pkg::OFS_CTRL, 32'h0002_0000);
    bus(1'h0, asl_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK("error clear", 1'h0, r[17])
  endtask

  task automatic t_busy_drop();
    int k;
    bus(1'h1, asl_pkg::OFS_MEM, 32'h0000_0700);
    bus(1'h1, 8'h24, 32'h0000_003c);
    // long external run, then a register write and a second start while busy
    bus(1'h1, asl_pkg::OFS_CTRL, 32'h0000_0851);
    bus(1'h1, 8'h24, 32'h0000_0055);
    bus(1'h1, asl_pkg::OFS_CTRL, 32'h0000_0001);
    settle(k);
    bus(1'h0, 8'h24, 32'h0000_0000);
    `CHK("acc after busy writes", 8'h3c, r[7:0])
  endtask

  task automatic report_and_stop();
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    t_reset();
    t_forms();
    t_refuse();
    t_busy_drop();
    report_and_stop();
  end
endmodule

`default_nettype wire
